/* tsp_defines.svh */
// Offsets, field positions, reset values and counts of the trip/sleep loader.
// Assumes inclusion by bare name from the package and the main module.
`ifndef TSP_DEFINES_SVH
`define TSP_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define TSP_BANK1_FIRST     8'h20
`define TSP_BANK1_LAST      8'h7F
`define TSP_BANK1_DEPTH     96
`define TSP_BANK2_FIRST     8'h80
`define TSP_BANK2_LAST      8'h84
`define TSP_BANK2_DEPTH     5
`define TSP_INIT_FIRST      8'h20
`define TSP_INIT_LAST       8'h87
`define TSP_OFS_TRIP_CTRL   8'h76
`define TSP_OFS_IRQ_STATUS  8'hF0
`define TSP_OFS_IRQ_MASK    8'hF1
`define TSP_OFS_MODE_STATUS 8'hF2

// ----------------------------------------------------------------------
// Trip threshold byte offsets (low byte of each 16-bit value)
// ----------------------------------------------------------------------
`define TSP_OFS_POS_CUR_TRIP 8'h60
`define TSP_OFS_NEG_CUR_TRIP 8'h64
`define TSP_OFS_PACK_TRIP    8'h68
`define TSP_OFS_CELL_TRIP    8'h6C
`define TSP_OFS_SHELF_TRIP   8'h70

// ----------------------------------------------------------------------
// Trip control fields and reset value
// ----------------------------------------------------------------------
`define TSP_BIT_CUR_EXIT    7
`define TSP_BIT_CUR_ENTRY   6
`define TSP_BIT_PACK_EXIT   5
`define TSP_BIT_CELL1_ENTRY 4
`define TSP_BIT_CELL2_ENTRY 3
`define TSP_BIT_SHELF_ENTRY 2
`define TSP_BIT_OVERFLOW    0
`define TSP_TRIP_CTRL_RESET 8'h00
`define TSP_TRIP_CTRL_WMASK 8'hFC

// ----------------------------------------------------------------------
// Interrupt status fields and reset values
// ----------------------------------------------------------------------
`define TSP_IRQ_SLEEP_ENTER 0
`define TSP_IRQ_SLEEP_EXIT  1
`define TSP_IRQ_SHELF_ENTER 2
`define TSP_IRQ_OVERFLOW    3
`define TSP_IRQ_INIT_DONE   4
`define TSP_IRQ_WIDTH       5
`define TSP_IRQ_RESET       5'h00

// ----------------------------------------------------------------------
// Supply threshold for leaving power-on hold
// ----------------------------------------------------------------------
`define TSP_POWER_ON_THRESHOLD 16'h6000

`endif

/* tsp_pkg.sv */
// Types and magnitude helper for the trip/sleep loader.
// Assumes tsp_defines.svh is on the include path.
`default_nettype none

package tsp_pkg;
  `include "tsp_defines.svh"

  typedef enum logic [1:0] {
    TSP_HOLD,
    TSP_LOAD,
    TSP_ACTIVE
  } tsp_seq_t;

  typedef enum logic [1:0] {
    TSP_MODE_RUN,
    TSP_MODE_SAMPLE_SLEEP,
    TSP_MODE_SHELF_SLEEP,
    TSP_MODE_OFF
  } tsp_mode_t;

  // Sign bit dropped, magnitude kept
  function automatic logic [14:0] tsp_mag(input logic [15:0] value);
    tsp_mag = value[14:0];
  endfunction
endpackage

`default_nettype wire

/* tsp_trip_if.sv */
// Carrier between the main module and the trip comparator.
// Assumes one clock domain; the comparator is purely combinational.
`default_nettype none

interface tsp_trip_if;
  logic [15:0] pos_cur_trip;
  logic [15:0] neg_cur_trip;
  logic [15:0] pack_voltage_threshold;
  logic [15:0] cell_voltage_threshold;
  logic [15:0] shelf_threshold;
  logic [15:0] current_result;
  logic [15:0] pack_voltage_result;
  logic [15:0] first_cell_result;
  logic [15:0] second_cell_result;
  logic [7:0]  trip_control;
  logic        want_sleep_enter;
  logic        want_sleep_exit;
  logic        want_shelf_enter;

  modport source (
    output pos_cur_trip, neg_cur_trip, pack_voltage_threshold, cell_voltage_threshold,
    output shelf_threshold, current_result, pack_voltage_result, first_cell_result,
    output second_cell_result, trip_control,
    input  want_sleep_enter, want_sleep_exit, want_shelf_enter
  );

  modport judge (
    input  pos_cur_trip, neg_cur_trip, pack_voltage_threshold, cell_voltage_threshold,
    input  shelf_threshold, current_result, pack_voltage_result, first_cell_result,
    input  second_cell_result, trip_control,
    output want_sleep_enter, want_sleep_exit, want_shelf_enter
  );
endinterface

`default_nettype wire

/* tsp_trip_cmp.sv */
// Trip comparator: decides sleep entry, exit and shelf entry.
// Assumes results and thresholds are stable while the main module samples.
`default_nettype none
`include "tsp_defines.svh"

module tsp_trip_cmp
  import tsp_pkg::*;
(
  tsp_trip_if.judge trip
);

  // ----------------------------------------------------------------------
  // Magnitude comparisons
  // ----------------------------------------------------------------------
  always_comb begin
    trip.want_sleep_enter = 1'b0;
    trip.want_sleep_exit  = 1'b0;
    trip.want_shelf_enter = 1'b0;
    if (trip.trip_control[`TSP_BIT_CUR_EXIT] &&
        (tsp_mag(trip.current_result) > tsp_mag(trip.pos_cur_trip))) begin
      trip.want_sleep_exit = 1'b1;
    end
    if (trip.trip_control[`TSP_BIT_PACK_EXIT] &&
        (tsp_mag(trip.pack_voltage_result) >
         tsp_mag(trip.pack_voltage_threshold))) begin
      trip.want_sleep_exit = 1'b1;
    end
    if (trip.trip_control[`TSP_BIT_CUR_ENTRY] &&
        (tsp_mag(trip.current_result) < tsp_mag(trip.neg_cur_trip))) begin
      trip.want_sleep_enter = 1'b1;
    end
    if (trip.trip_control[`TSP_BIT_CELL1_ENTRY] &&
        (tsp_mag(trip.first_cell_result) <
         tsp_mag(trip.cell_voltage_threshold))) begin
      trip.want_sleep_enter = 1'b1;
    end
    if (trip.trip_control[`TSP_BIT_CELL2_ENTRY] &&
        (tsp_mag(trip.second_cell_result) <
         tsp_mag(trip.cell_voltage_threshold))) begin
      trip.want_sleep_enter = 1'b1;
    end
    if (trip.trip_control[`TSP_BIT_SHELF_ENTRY] &&
        (tsp_mag(trip.pack_voltage_result) < tsp_mag(trip.shelf_threshold))) begin
      trip.want_shelf_enter = 1'b1;
    end
  end

endmodule

`default_nettype wire

/* tsp_top.sv */
// Trip-driven sleep control and power-on register loader.
// Assumes an EEPROM read port that answers one cycle after the read strobe,
// digitised supply and conversion results synchronous to ref_clk_in.
//
// Functional notes
// - Current above positive trip leaves sleep; below negative trip enters it.
// - First cell below cell threshold enters sample-sleep when enabled.
// - Second cell below the same cell threshold enters sample-sleep when enabled.
// - Pack voltage below shelf threshold enters shelf-sleep when enabled.
// - Conversion overflow sets the overflow flag in trip control bit 0.
// - Comparisons use magnitudes only; sign bit ignored.
// - Held in reset while first cell supply is below the power-on threshold.
// - After initialization the block enters run mode with continuous conversion.
// - Power-on load reads EEPROM locations 0x020 through 0x087.
// - Bytes 0x020-0x07F land one-to-one in bank 1.
// - Bytes 0x080-0x084 land in bank 2 calibration registers.
`default_nettype none
`include "tsp_defines.svh"

module tsp_top
  import tsp_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire logic [15:0] first_cell_input_in,
  input  wire logic        result_valid_in,
  input  wire logic [15:0] current_result_in,
  input  wire logic [15:0] pack_voltage_result_in,
  input  wire logic [15:0] first_cell_result_in,
  input  wire logic [15:0] second_cell_result_in,
  input  wire logic        adc_overflow_in,
  output logic             eeprom_rd_out,
  output logic      [7:0]  eeprom_addr_out,
  input  wire logic [7:0]  eeprom_data_in,
  output logic             device_reset_out,
  output logic      [1:0]  power_mode_out,
  output logic             continuous_conv_out,
  output logic             irq_out
);

  // ----------------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------------
  logic [7:0]              bank1_mem [0:`TSP_BANK1_DEPTH-1];
  logic [7:0]              bank2_mem [0:`TSP_BANK2_DEPTH-1];
  logic [7:0]              trip_control;
  logic [`TSP_IRQ_WIDTH-1:0] irq_status;
  logic [`TSP_IRQ_WIDTH-1:0] irq_mask;
  logic [`TSP_IRQ_WIDTH-1:0] irq_events;
  tsp_seq_t                seq;
  tsp_mode_t               mode;
  logic [7:0]              load_ptr;
  logic                    load_issue_done;
  logic                    cap_pend;
  logic [7:0]              cap_addr;
  logic                    supply_ok;
  logic                    cap_last;
  logic                    sw_wr_bank;
  logic                    sleep_enter_evt;
  logic                    sleep_exit_evt;
  logic                    shelf_enter_evt;
  logic                    init_done_evt;
  logic [7:0]              next_rdata;

  tsp_trip_if trip ();

  // ----------------------------------------------------------------------
  // Address helpers
  // ----------------------------------------------------------------------
  function automatic logic in_bank1(input logic [7:0] a);
    in_bank1 = (a >= `TSP_BANK1_FIRST) && (a <= `TSP_BANK1_LAST);
  endfunction

  function automatic logic in_bank2(input logic [7:0] a);
    in_bank2 = (a >= `TSP_BANK2_FIRST) && (a <= `TSP_BANK2_LAST);
  endfunction

  function automatic logic [6:0] bank1_idx(input logic [7:0] a);
    bank1_idx = 7'(a - `TSP_BANK1_FIRST);
  endfunction

  function automatic logic [2:0] bank2_idx(input logic [7:0] a);
    bank2_idx = 3'(a - `TSP_BANK2_FIRST);
  endfunction

  // Thresholds stored little-endian, low byte at the printed offset
  function automatic logic [15:0] word_at(input logic [7:0] a);
    word_at = {bank1_mem[bank1_idx(8'(a + 8'h01))], bank1_mem[bank1_idx(a)]};
  endfunction

  // ----------------------------------------------------------------------
  // Comparator hookup
  // ----------------------------------------------------------------------
  assign trip.pos_cur_trip           = word_at(`TSP_OFS_POS_CUR_TRIP);
  assign trip.neg_cur_trip           = word_at(`TSP_OFS_NEG_CUR_TRIP);
  assign trip.pack_voltage_threshold = word_at(`TSP_OFS_PACK_TRIP);
  assign trip.cell_voltage_threshold = word_at(`TSP_OFS_CELL_TRIP);
  assign trip.shelf_threshold        = word_at(`TSP_OFS_SHELF_TRIP);
  assign trip.current_result         = current_result_in;
  assign trip.pack_voltage_result    = pack_voltage_result_in;
  assign trip.first_cell_result      = first_cell_result_in;
  assign trip.second_cell_result     = second_cell_result_in;
  assign trip.trip_control           = trip_control;

  tsp_trip_cmp u_cmp (
    .trip (trip)
  );

  // ----------------------------------------------------------------------
  // Supply and load decode
  // ----------------------------------------------------------------------
  assign supply_ok  = first_cell_input_in >= `TSP_POWER_ON_THRESHOLD;
  assign cap_last   = cap_pend && (cap_addr == `TSP_INIT_LAST);
  // Software writes to the banks are refused while the loader owns them
  assign sw_wr_bank = reg_wr_in && (seq == TSP_ACTIVE);

  // ----------------------------------------------------------------------
  // Power-on sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      seq <= TSP_HOLD;
    end else if (!supply_ok) begin
      seq <= TSP_HOLD;
    end else begin
      case (seq)
        TSP_HOLD: begin
          seq <= TSP_LOAD;
        end
        TSP_LOAD: begin
          if (cap_last) begin
            seq <= TSP_ACTIVE;
          end
        end
        default: begin
          seq <= seq;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // EEPROM read issue
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      load_ptr        <= `TSP_INIT_FIRST;
      load_issue_done <= 1'b0;
      eeprom_rd_out   <= 1'b0;
      eeprom_addr_out <= 8'h00;
    end else if (seq != TSP_LOAD) begin
      load_ptr        <= `TSP_INIT_FIRST;
      load_issue_done <= 1'b0;
      eeprom_rd_out   <= 1'b0;
      eeprom_addr_out <= 8'h00;
    end else if (!load_issue_done && supply_ok) begin
      eeprom_rd_out   <= 1'b1;
      eeprom_addr_out <= load_ptr;
      load_ptr        <= 8'(load_ptr + 8'h01);
      load_issue_done <= load_ptr == `TSP_INIT_LAST;
    end else begin
      eeprom_rd_out <= 1'b0;
    end
  end

  // Data arrives one cycle after the strobe seen by the EEPROM
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cap_pend <= 1'b0;
      cap_addr <= 8'h00;
    end else begin
      cap_pend <= eeprom_rd_out && (seq == TSP_LOAD) && supply_ok;
      cap_addr <= eeprom_addr_out;
    end
  end

  // ----------------------------------------------------------------------
  // Register banks
  // ----------------------------------------------------------------------
  // No reset on the arrays: the loader fills them before use
  always_ff @(posedge ref_clk_in) begin
    if (cap_pend && (seq == TSP_LOAD)) begin
      if (in_bank1(cap_addr)) begin
        bank1_mem[bank1_idx(cap_addr)] <= eeprom_data_in;
      end else if (in_bank2(cap_addr)) begin
        bank2_mem[bank2_idx(cap_addr)] <= eeprom_data_in;
      end
    end else if (sw_wr_bank) begin
      if (in_bank1(reg_addr_in)) begin
        bank1_mem[bank1_idx(reg_addr_in)] <= reg_wdata_in;
      end else if (in_bank2(reg_addr_in)) begin
        bank2_mem[bank2_idx(reg_addr_in)] <= reg_wdata_in;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Trip control register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      trip_control <= `TSP_TRIP_CTRL_RESET;
    end else if (seq == TSP_HOLD) begin
      trip_control <= `TSP_TRIP_CTRL_RESET;
    end else if (cap_pend && (seq == TSP_LOAD) && (cap_addr == `TSP_OFS_TRIP_CTRL)) begin
      // Reserved bit 1 forced low even if the image holds a one
      trip_control <= eeprom_data_in & (`TSP_TRIP_CTRL_WMASK | 8'h01);
    end else begin
      if (sw_wr_bank && (reg_addr_in == `TSP_OFS_TRIP_CTRL)) begin
        trip_control[7:2] <= reg_wdata_in[7:2];
        if (!reg_wdata_in[`TSP_BIT_OVERFLOW]) begin
          trip_control[`TSP_BIT_OVERFLOW] <= 1'b0;
        end
      end
      // Set beats the software clear in the same cycle
      if (adc_overflow_in && (seq == TSP_ACTIVE)) begin
        trip_control[`TSP_BIT_OVERFLOW] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Power mode control
  // ----------------------------------------------------------------------
  assign sleep_enter_evt = (seq == TSP_ACTIVE) && result_valid_in &&
                           (mode == TSP_MODE_RUN) && trip.want_sleep_enter &&
                           !trip.want_shelf_enter;
  assign sleep_exit_evt  = (seq == TSP_ACTIVE) && result_valid_in &&
                           (mode == TSP_MODE_SAMPLE_SLEEP) && trip.want_sleep_exit &&
                           !trip.want_shelf_enter;
  assign shelf_enter_evt = (seq == TSP_ACTIVE) && result_valid_in &&
                           (mode != TSP_MODE_SHELF_SLEEP) && trip.want_shelf_enter;
  assign init_done_evt   = (seq == TSP_LOAD) && cap_last && supply_ok;

  // Shelf-sleep is left only through a fresh power-on sequence
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode <= TSP_MODE_OFF;
    end else if (seq != TSP_ACTIVE) begin
      mode <= init_done_evt ? TSP_MODE_RUN : TSP_MODE_OFF;
    end else if (shelf_enter_evt) begin
      mode <= TSP_MODE_SHELF_SLEEP;
    end else if (sleep_enter_evt) begin
      mode <= TSP_MODE_SAMPLE_SLEEP;
    end else if (sleep_exit_evt) begin
      mode <= TSP_MODE_RUN;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      device_reset_out    <= 1'b1;
      power_mode_out      <= 2'h3;
      continuous_conv_out <= 1'b0;
    end else begin
      device_reset_out    <= !((seq == TSP_ACTIVE) || init_done_evt) || !supply_ok;
      if (!supply_ok) begin
        power_mode_out      <= 2'(TSP_MODE_OFF);
        continuous_conv_out <= 1'b0;
      end else if (seq != TSP_ACTIVE) begin
        power_mode_out      <= init_done_evt ? 2'(TSP_MODE_RUN) : 2'(TSP_MODE_OFF);
        continuous_conv_out <= init_done_evt;
      end else if (shelf_enter_evt) begin
        power_mode_out      <= 2'(TSP_MODE_SHELF_SLEEP);
        continuous_conv_out <= 1'b0;
      end else if (sleep_enter_evt) begin
        power_mode_out      <= 2'(TSP_MODE_SAMPLE_SLEEP);
        continuous_conv_out <= 1'b0;
      end else if (sleep_exit_evt) begin
        power_mode_out      <= 2'(TSP_MODE_RUN);
        continuous_conv_out <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  always_comb begin
    irq_events = '0;
    irq_events[`TSP_IRQ_SLEEP_ENTER] = sleep_enter_evt;
    irq_events[`TSP_IRQ_SLEEP_EXIT]  = sleep_exit_evt;
    irq_events[`TSP_IRQ_SHELF_ENTER] = shelf_enter_evt;
    irq_events[`TSP_IRQ_OVERFLOW]    = adc_overflow_in && (seq == TSP_ACTIVE);
    irq_events[`TSP_IRQ_INIT_DONE]   = init_done_evt;
  end

  // Write-one-to-clear; a new event in the clear cycle survives
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_status <= `TSP_IRQ_RESET;
    end else if (reg_wr_in && (reg_addr_in == `TSP_OFS_IRQ_STATUS)) begin
      irq_status <= (irq_status & ~reg_wdata_in[`TSP_IRQ_WIDTH-1:0]) | irq_events;
    end else begin
      irq_status <= irq_status | irq_events;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_mask <= `TSP_IRQ_RESET;
    end else if (reg_wr_in && (reg_addr_in == `TSP_OFS_IRQ_MASK)) begin
      irq_mask <= reg_wdata_in[`TSP_IRQ_WIDTH-1:0];
    end
  end

  // One cycle behind the status bit, keeps the output a flop
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr_in == `TSP_OFS_TRIP_CTRL) begin
      next_rdata = trip_control;
    end else if (reg_addr_in == `TSP_OFS_IRQ_STATUS) begin
      next_rdata = {3'h0, irq_status};
    end else if (reg_addr_in == `TSP_OFS_IRQ_MASK) begin
      next_rdata = {3'h0, irq_mask};
    end else if (reg_addr_in == `TSP_OFS_MODE_STATUS) begin
      next_rdata = {4'h0, 2'(seq), 2'(mode)};
    end else if (in_bank1(reg_addr_in)) begin
      next_rdata = bank1_mem[bank1_idx(reg_addr_in)];
    end else if (in_bank2(reg_addr_in)) begin
      next_rdata = bank2_mem[bank2_idx(reg_addr_in)];
    end
  end

  // Data valid only in the cycle after the read strobe
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= next_rdata;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

endmodule

`default_nettype wire

/* tsp_sva.sv */
// Checker: port-level properties of tsp_top, bound from the testbench.
// Assumes one clock domain and the asynchronous active-high reset.
`default_nettype none

module tsp_sva (
  input wire logic        ref_clk_in,
  input wire logic        sys_rst_in,
  input wire logic [15:0] first_cell_input_in,
  input wire logic        result_valid_in,
  input wire logic        eeprom_rd_out,
  input wire logic [7:0]  eeprom_addr_out,
  input wire logic        device_reset_out,
  input wire logic [1:0]  power_mode_out,
  input wire logic        continuous_conv_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // ------------------------------------------
  // Power-on sequence
  // ------------------------------------------
  a_hold_low_supply: assert property (first_cell_input_in < 16'h6000
    |=> device_reset_out && power_mode_out == 2'h3) else $error("no hold on low supply");
  a_load_first_addr: assert property ($rose(eeprom_rd_out) |-> eeprom_addr_out == 8'h20)
    else $error("load starts at wrong address");
  a_load_addr_range: assert property (eeprom_rd_out
    |-> eeprom_addr_out >= 8'h20 && eeprom_addr_out <= 8'h87) else $error("load out of range");
  a_load_addr_step: assert property (eeprom_rd_out && eeprom_addr_out != 8'h87
    && first_cell_input_in >= 16'h6000
    |=> eeprom_rd_out && eeprom_addr_out == $past(eeprom_addr_out) + 8'h01)
    else $error("load not ascending back to back");
  a_load_done_run: assert property (eeprom_rd_out && eeprom_addr_out == 8'h87
    && first_cell_input_in >= 16'h6000 |-> ##2 !device_reset_out && power_mode_out == 2'h0
    && continuous_conv_out) else $error("run mode not entered after load");
  a_run_with_conv: assert property (continuous_conv_out
    |-> power_mode_out == 2'h0 && !device_reset_out) else $error("conversion outside run");
  // ------------------------------------------
  // Trip driven mode changes
  // ------------------------------------------
  // Mode outputs move exactly one cycle after the result pulse
  a_mode_on_result: assert property (power_mode_out != $past(power_mode_out)
    && !device_reset_out && !$past(device_reset_out)
    |-> $past(result_valid_in)) else $error("mode change w/o result");
  a_shelf_is_sticky: assert property (power_mode_out == 2'h2
    && first_cell_input_in >= 16'h6000 |=> power_mode_out == 2'h2) else $error("shelf left");
  cover property ($fell(device_reset_out));
  cover property (power_mode_out == 2'h1);
  cover property (power_mode_out == 2'h2);
endmodule

`default_nettype wire

/* tb.sv */
// Testbench: drives registers, supply, results and EEPROM data of tsp_top.
// Assumes the design files and tsp_sva.sv are compiled before this file.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------
  // Signals, clock and EEPROM stand-in
  // ------------------------------------------
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, vld = 1'b0, ovf = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, ee_data = 8'hA5, rdata, ee_addr;
  logic [15:0] sup = 16'h1000, cur = 16'h0000, pack = 16'h0000, c1 = 16'h0000, c2 = 16'h0000;
  logic        ee_rd, dev_rst, cont, irq;
  logic [1:0]  mode;
  int          n_fail = 0, checked = 0, n_rd = 0;

  tsp_top i_tsp_top (.ref_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .first_cell_input_in(sup), .result_valid_in(vld), .current_result_in(cur),
    .pack_voltage_result_in(pack), .first_cell_result_in(c1), .second_cell_result_in(c2),
    .adc_overflow_in(ovf), .eeprom_rd_out(ee_rd), .eeprom_addr_out(ee_addr),
    .eeprom_data_in(ee_data), .device_reset_out(dev_rst), .power_mode_out(mode),
    .continuous_conv_out(cont), .irq_out(irq));

  always #4 clk = ~clk;
  // Byte equals its address except at 0x76; idle bus shows a pattern, not the last byte
  always @(posedge clk) begin
    // Reserved trip control bit kept zero in the image
    ee_data <= ee_rd ? ((ee_addr == 8'h76) ? 8'h74 : ee_addr) : 8'hA5;
    if (ee_rd) n_rd <= n_rd + 1;
  end
  // ------------------------------------------
  // Tasks
  // ------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, e});
  endtask
  task automatic trip(input logic [7:0] ctl, input logic [15:0] i, p, a, b, input logic [1:0] m);
    wr_reg(8'h76, ctl);
    @(posedge clk);
    cur <= i;
    pack <= p;
    c1 <= a;
    c2 <= b;
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({14'h0000, mode}, {14'h0000, m});
  endtask
  task automatic finish_test();
    $display("Counts: checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ------------------------------------------
  // Tests
  // ------------------------------------------
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    #1 chk({14'h0000, dev_rst, cont}, 16'h0002);
    chk({14'h0000, mode}, 16'h0003);
    @(posedge clk);
    sup <= 16'h7000;
    for (int k = 0; k < 200 && dev_rst !== 1'b0; k++) @(posedge clk);
    #1 chk(n_rd[15:0], 16'h0068);
    chk({13'h0000, mode, cont}, 16'h0001);
    rd_reg(8'h20, 8'h20);
    rd_reg(8'h7F, 8'h7F);
    rd_reg(8'h80, 8'h80);
    rd_reg(8'h84, 8'h84);
    rd_reg(8'h76, 8'h74);
    rd_reg(8'h90, 8'h00);
    wr_reg(8'hF1, 8'h00);
    trip(8'h00, 16'h8001, 16'h8001, 16'h8001, 16'h8001, 2'h0);
    trip(8'h40, 16'hFFFF, 16'h0000, 16'h7FFF, 16'h7FFF, 2'h0);
    trip(8'h40, 16'h8001, 16'h0000, 16'h7FFF, 16'h7FFF, 2'h1);
    trip(8'h80, 16'h7FFF, 16'h0000, 16'h7FFF, 16'h7FFF, 2'h0);
    trip(8'h10, 16'h0000, 16'h0000, 16'h8001, 16'h7FFF, 2'h1);
    trip(8'h20, 16'h0000, 16'hFFFF, 16'h7FFF, 16'h7FFF, 2'h0);
    trip(8'h08, 16'h0000, 16'h0000, 16'h7FFF, 16'h8001, 2'h1);
    trip(8'h80, 16'h7FFF, 16'h0000, 16'h7FFF, 16'h7FFF, 2'h0);
    chk({15'h0000, irq}, 16'h0000);
    rd_reg(8'hF0, 8'h13);
    wr_reg(8'hF0, 8'h1F);
    wr_reg(8'hF1, 8'h08);
    @(posedge clk);
    ovf <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({15'h0000, irq}, 16'h0001);
    rd_reg(8'h76, 8'h81);
    wr_reg(8'h76, 8'h80);
    wr_reg(8'hF0, 8'h08);
    rd_reg(8'h76, 8'h80);
    chk({15'h0000, irq}, 16'h0000);
    trip(8'h04, 16'h0000, 16'h8001, 16'h7FFF, 16'h7FFF, 2'h2);
    rd_reg(8'hF2, 8'h0A);
    @(posedge clk);
    sup <= 16'h1000;
    repeat (3) @(posedge clk);
    #1 chk({13'h0000, dev_rst, mode}, 16'h0007);
    finish_test();
  end
endmodule

bind tsp_top tsp_sva i_tsp_sva (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
  .first_cell_input_in(first_cell_input_in), .result_valid_in(result_valid_in),
  .eeprom_rd_out(eeprom_rd_out), .eeprom_addr_out(eeprom_addr_out),
  .device_reset_out(device_reset_out), .power_mode_out(power_mode_out),
  .continuous_conv_out(continuous_conv_out));

`default_nettype wire
